// ==== hpc_pkg.sv ====
// Constants shared by the host port control pin logic.
// Assumes a single 50 MHz clock domain, ref_clk.
package hpc_pkg;
   localparam int DATA_W = 8;
   localparam int IRQ_W = 4;
   localparam int PIN_W = 3;
   localparam int CNT_W = 8;
   // Host interface modes
   localparam logic [1:0] MODE_ASYNC_A = 2'h0;
   localparam logic [1:0] MODE_ASYNC_B = 2'h1;
   localparam logic [1:0] MODE_SYNC_CLK = 2'h2;
   localparam logic [1:0] MODE_BURST = 2'h3;
   // Positions of the pin bits in the synchroniser vector
   localparam int PIN_DBEN = 0;
   localparam int PIN_BLAST = 1;
   localparam int PIN_ASEL = 2;
   // Synchroniser reset level: enables/last idle high, strap high
   localparam logic [PIN_W-1:0] PIN_RST = 3'h7;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic IRQ_LEVEL = 1'b0;
   typedef enum logic [1:0] {
      ST_SINGLE = 2'b01,
      ST_BURST = 2'b10
   } hpc_burst_e;
endpackage

// ==== hpc_sync_if.sv ====
// Carrier between the pin synchroniser and the control logic.
// Assumes both ends run on ref_clk.
`timescale 1ns/100ps
interface hpc_sync_if;
   logic [hpc_pkg::PIN_W-1:0] raw;
   logic [hpc_pkg::PIN_W-1:0] synced;
   modport sync (input raw, output synced);
   modport user (output raw, input synced);
endinterface

// ==== hpc_sync.sv ====
// Two-stage synchroniser for the asynchronous host pins.
// Assumes the raw pins may change at any time relative to ref_clk.
`timescale 1ns/100ps
module hpc_sync (
   input wire logic ref_clk,
   input wire logic rst_n,
   hpc_sync_if.sync pins
);
   import hpc_pkg::*;
   ////////////////////////////////////////////////////////////////////
   // One pair of flops per pin; stage one feeds stage two only
   genvar i;
   generate
      for (i = 0; i < PIN_W; i++) begin : g_bit
         logic meta_reg;
         logic sync_reg;
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_reg <= PIN_RST[i];
               sync_reg <= PIN_RST[i];
            end else begin
               meta_reg <= pins.raw[i];
               sync_reg <= meta_reg;
            end
         end
         assign pins.synced[i] = sync_reg;
      end
   endgenerate
endmodule

// ==== hpc_top.sv ====
// Control pins of the 8-bit parallel host port: bus enable, burst end,
// interrupt request, cycle completion and reset handling.
// Assumes a 50 MHz ref_clk; host pins are asynchronous to it, while the
// core-side inputs come from logic on ref_clk.
`timescale 1ns/100ps
// Functional notes
// - Data bus enabled only while enable pin low
// - Low last-of-burst marks final burst transfer
// - Interrupt pin pulled low while service requested
// - Reset is asynchronous and tristates every output
// - Reset returns every register to default
module hpc_top (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic data_bus_drive_enable_n,
   input wire logic burst_final_transfer_n,
   input wire logic addr_loc_sel,
   input wire logic [hpc_pkg::DATA_W-1:0] data_in,
   output logic [hpc_pkg::DATA_W-1:0] data_out,
   output logic data_oe,
   output logic service_request_n_o,
   output logic service_request_n_oe,
   output logic cycle_complete_n_o,
   output logic cycle_complete_n_oe,
   input wire logic [1:0] host_mode,
   input wire logic core_read_dir,
   input wire logic [hpc_pkg::DATA_W-1:0] core_rd_data,
   input wire logic core_xfer_done,
   input wire logic [hpc_pkg::IRQ_W-1:0] core_irq_src,
   output logic [hpc_pkg::DATA_W-1:0] core_wr_data,
   output logic bus_enabled,
   output logic access_allowed,
   output logic burst_active,
   output logic burst_last,
   output logic [hpc_pkg::CNT_W-1:0] burst_count
);
   import hpc_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   // Two edges of latency on every host pin buy freedom from metastability;
   // a host that turns the bus around must allow for that delay
   hpc_sync_if pins_if ();
   assign pins_if.raw = {addr_loc_sel, burst_final_transfer_n, data_bus_drive_enable_n};

   hpc_sync u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pins(pins_if.sync)
   );

   logic dben_n_s;
   logic blast_n_s;
   logic asel_s;
   logic burst_mode;
   assign dben_n_s = pins_if.synced[PIN_DBEN];
   assign blast_n_s = pins_if.synced[PIN_BLAST];
   assign asel_s = pins_if.synced[PIN_ASEL];
   assign burst_mode = (host_mode == MODE_BURST);

   ////////////////////////////////////////////////////////////////////
   // Data bus; read data held in flops so the pins never glitch
   logic [DATA_W-1:0] rd_data_reg;
   logic [DATA_W-1:0] wr_data_reg;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_reg <= DATA_RST;
         wr_data_reg <= DATA_RST;
      end else begin
         rd_data_reg <= core_rd_data;
         if (!dben_n_s && !core_read_dir) begin
            wr_data_reg <= data_in; // Capture only while the bus is enabled
         end
      end
   end

   // Reset gates the enables directly, no clock edge needed
   assign bus_enabled = rst_n & ~dben_n_s;
   assign data_oe = bus_enabled & core_read_dir;
   assign data_out = rd_data_reg;
   assign core_wr_data = wr_data_reg;

   // Strap low blocks register access; the board must tie it high
   assign access_allowed = asel_s;

   ////////////////////////////////////////////////////////////////////
   // Interrupt request: open drain, low level only
   logic irq_reg;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |core_irq_src;
      end
   end
   assign service_request_n_o = IRQ_LEVEL;
   assign service_request_n_oe = rst_n & irq_reg;

   ////////////////////////////////////////////////////////////////////
   // Cycle completion: active low except in the clocked mode
   logic done_reg;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= core_xfer_done;
      end
   end
   // Outside the clocked mode the inactive level makes the host stretch its cycle
   assign cycle_complete_n_o = (host_mode == MODE_SYNC_CLK) ? done_reg : ~done_reg;
   assign cycle_complete_n_oe = rst_n;

   ////////////////////////////////////////////////////////////////////
   // Burst tracking; the pin is ignored outside burst mode, since
   // boards tie it to ground there and it would end every access
   hpc_burst_e state_reg;
   hpc_burst_e state_next;
   logic last_now;
   assign last_now = burst_mode & core_xfer_done & ~blast_n_s;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_SINGLE: begin
            if (burst_mode && core_xfer_done && blast_n_s) begin
               state_next = ST_BURST;
            end
         end
         ST_BURST: begin
            if (last_now || !burst_mode) begin
               state_next = ST_SINGLE;
            end
         end
         default: state_next = ST_SINGLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_SINGLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Transfers counted in the current burst, final one included
   // Eight bits wrap silently on very long bursts; only the low byte is kept
   logic [CNT_W-1:0] count_reg;
   logic last_reg;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= CNT_RST;
         last_reg <= 1'b0;
      end else begin
         last_reg <= last_now;
         if (burst_mode && core_xfer_done) begin
            count_reg <= (state_reg == ST_SINGLE) ? CNT_ONE : count_reg + CNT_ONE;
         end
      end
   end
   assign burst_active = (state_reg == ST_BURST);
   assign burst_last = last_reg;
   assign burst_count = count_reg;

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // Pin-level checks; the pin seen two edges back decides, since the
   // synchroniser adds exactly that latency to every host pin
   a_bus_enable: assert property ($past(data_bus_drive_enable_n, 2) |-> !data_oe)
      else $error("data bus driven while enable pin high");
   a_bus_read: assert property ($past(rst_n, 2) && $past(rst_n) && core_read_dir
      && !$past(data_bus_drive_enable_n, 2) |-> data_oe)
      else $error("data bus not driven on enabled read");
   a_strap_pass: assert property ($past(rst_n, 2) && $past(rst_n)
      |-> access_allowed == $past(addr_loc_sel, 2))
      else $error("strap level not passed to access gate");

   // Burst checks
   a_last_pulse: assert property (burst_mode && core_xfer_done && !blast_n_s
      |=> burst_last && state_reg == ST_SINGLE)
      else $error("final burst transfer not flagged");
   a_last_mode: assert property (!burst_mode |=> !burst_last)
      else $error("burst end flagged outside burst mode");
   a_burst_exit: assert property (!burst_mode |=> !burst_active)
      else $error("burst kept open after leaving burst mode");
   // Counter restarts at one on a fresh burst and steps by one inside it
   a_count_first: assert property (burst_mode && core_xfer_done
      && state_reg == ST_SINGLE |=> burst_count == CNT_ONE)
      else $error("burst count not restarted at one");
   a_count_step: assert property (burst_mode && core_xfer_done
      && state_reg == ST_BURST |=> burst_count == $past(burst_count) + CNT_ONE)
      else $error("burst count not advanced by one");

   // Interrupt and ready checks
   a_irq_drive: assert property ($rose(|core_irq_src) |=> service_request_n_oe
      && service_request_n_o == 1'b0)
      else $error("interrupt not driven low");
   a_irq_release: assert property (core_irq_src == '0 |=> !service_request_n_oe)
      else $error("interrupt not released when idle");
   // Ready stands active for the one cycle after each completed transfer
   a_ready_pulse: assert property (core_xfer_done
      |=> cycle_complete_n_o == (host_mode == MODE_SYNC_CLK))
      else $error("ready not active after completed transfer");

   // Reset checks run while reset is low, so they override the default disable
   a_reset_tristate: assert property (@(posedge ref_clk) disable iff (1'b0)
      !rst_n |-> !data_oe && !service_request_n_oe && !cycle_complete_n_oe)
      else $error("output driven during reset");
   a_reset_default: assert property (@(posedge ref_clk) disable iff (1'b0)
      !rst_n |-> state_reg == ST_SINGLE && count_reg == CNT_RST && !burst_last)
      else $error("register not at default during reset");

   // Main scenarios
   c_burst_end: cover property (burst_active ##[1:20] burst_last);
   c_irq: cover property ($rose(service_request_n_oe));
   c_read: cover property (data_oe ##1 !data_oe);
   c_burst_exit: cover property (burst_active && !burst_mode);
endmodule

// ==== hpc_host_model.sv ====
// Host-side pin model for the parallel host port control pins.
// Assumes the bench issues requests on ref_clk; the strap is board level.
`timescale 1ns/100ps
module hpc_host_model (
   input wire logic ref_clk,
   input wire logic [1:0] host_mode,
   input wire logic bus_req,
   input wire logic wr_req,
   input wire logic last_req,
   input wire logic [7:0] wdata,
   input wire logic cycle_complete_n_o,
   output logic data_bus_drive_enable_n,
   output logic burst_final_transfer_n,
   output logic addr_loc_sel,
   output logic [7:0] data_in,
   output logic host_wait
);
   import hpc_pkg::*;
   logic [7:0] last_reg = 8'h00;
   ////////////////////////////////////////////////////////////////////
   // Strap and enable pins as the board and host drive them
   assign addr_loc_sel = 1'b1;
   assign data_bus_drive_enable_n = ~bus_req;
   // Grounded outside burst mode, low only on the final burst access
   assign burst_final_transfer_n = (host_mode == MODE_BURST) ? ~last_req : 1'b0;
   // Undriven bus flips every cycle so a stale value never looks valid
   assign data_in = wr_req ? wdata : ~last_reg;
   always_ff @(posedge ref_clk) begin
      last_reg <= data_in;
   end
   // Async modes: the host stretches its cycle while ready stays high
   assign host_wait = (host_mode != MODE_SYNC_CLK) && cycle_complete_n_o;
endmodule

// ==== test_host_port_control_pins.sv ====
// Self-checking bench for the host port control pins.
// Assumes hpc_pkg, hpc_sync_if, hpc_sync and hpc_top are compiled first.
`timescale 1ns/100ps
module test_host_port_control_pins;
   import hpc_pkg::*;
   logic ref_clk = 0, rst_n = 1, bus_req = 0, wr_req = 0, last_req = 0;
   logic core_read_dir = 0, core_xfer_done = 0;
   logic [1:0] host_mode = MODE_ASYNC_A;
   logic [7:0] wdata = 8'h00, core_rd_data = 8'h00;
   logic [3:0] core_irq_src = 4'hf;
   logic data_bus_drive_enable_n, burst_final_transfer_n, addr_loc_sel, host_wait, data_oe;
   logic service_request_n_o, service_request_n_oe, cycle_complete_n_o, cycle_complete_n_oe;
   logic bus_enabled, access_allowed, burst_active, burst_last;
   logic [7:0] data_in, data_out, core_wr_data, burst_count;
   integer seed = 32'h7be394d4;
   int mismatches = 0, checks = 0, n, lens[$];
   ////////////////////////////////////////////////////////////////////
   // Clock, far side and device
   always #10 ref_clk = ~ref_clk;
   hpc_host_model i_host (.ref_clk, .host_mode, .bus_req, .wr_req, .last_req, .wdata,
      .cycle_complete_n_o, .data_bus_drive_enable_n, .burst_final_transfer_n,
      .addr_loc_sel, .data_in, .host_wait);
   hpc_top i_dut (.ref_clk, .rst_n, .data_bus_drive_enable_n, .burst_final_transfer_n,
      .addr_loc_sel, .data_in, .data_out, .data_oe, .service_request_n_o,
      .service_request_n_oe, .cycle_complete_n_o, .cycle_complete_n_oe, .host_mode,
      .core_read_dir, .core_rd_data, .core_xfer_done, .core_irq_src, .core_wr_data,
      .bus_enabled, .access_allowed, .burst_active, .burst_last, .burst_count);
   ////////////////////////////////////////////////////////////////////
   // Drive point is always 2 ns after the rising edge
   task step(input int k);
      repeat (k) @(posedge ref_clk);
      #2;
   endtask
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task tally_and_finish;
      if (mismatches == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Watchdog in case the sequence hangs
   initial begin
      #200000;
      mismatches++;
      tally_and_finish;
   end
   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      // Reset falls before the first edge so no flop is ever sampled unknown
      #2 rst_n = 0;
      step(12);
      chk("data_oe", 0, data_oe);
      chk("service_request_n_oe", 0, service_request_n_oe);
      chk("cycle_complete_n_oe", 0, cycle_complete_n_oe);
      chk("burst_count", 0, burst_count);
      rst_n = 1;
      core_irq_src = 4'h0;
      step(3);
      // Read then write with the bus enabled, then released
      bus_req = 1;
      core_read_dir = 1;
      core_rd_data = $random(seed);
      step(3);
      chk("data_oe", 1, data_oe);
      chk("data_out", core_rd_data, data_out);
      chk("access_allowed", 1, access_allowed);
      core_read_dir = 0;
      wr_req = 1;
      wdata = $random(seed);
      step(2);
      chk("core_wr_data", wdata, core_wr_data);
      chk("data_oe", 0, data_oe);
      bus_req = 0;
      wr_req = 0;
      core_read_dir = 1;
      step(3);
      chk("data_oe", 0, data_oe);
      chk("bus_enabled", 0, bus_enabled);
      // Interrupt sources, ending with none pending
      for (int i = 0; i < 9; i++) begin
         core_irq_src = (i < 8) ? 4'($random(seed)) : 4'h0;
         step(1);
         chk("service_request_n_oe", |core_irq_src, service_request_n_oe);
         chk("service_request_n_o", 0, service_request_n_o);
      end
      // Ready pulse level in every mode; mode 2 is active high
      for (int i = 0; i < 4; i++) begin
         host_mode = 2'(i);
         step(1);
         core_xfer_done = 1;
         step(1);
         core_xfer_done = 0;
         chk("cycle_complete_n_o", i == 2, cycle_complete_n_o);
         chk("host_wait", 0, host_wait);
         chk("cycle_complete_n_oe", 1, cycle_complete_n_oe);
         if (i < 3) chk("burst_last", 0, burst_last);
         step(1);
         chk("cycle_complete_n_o idle", i != 2, cycle_complete_n_o);
         chk("host_wait idle", i != 2, host_wait);
      end
      // Reset dropped between edges must act at once
      bus_req = 1;
      core_irq_src = 4'h1;
      step(3);
      rst_n = 0;
      #1;
      chk("data_oe", 0, data_oe);
      chk("service_request_n_oe", 0, service_request_n_oe);
      chk("cycle_complete_n_oe", 0, cycle_complete_n_oe);
      step(1);
      chk("burst_active", 0, burst_active);
      rst_n = 1;
      bus_req = 0;
      core_irq_src = 4'h0;
      step(3);
      // Bursts of random length; the last access is flagged
      host_mode = MODE_BURST;
      step(3);
      repeat (4) lens.push_back(($random(seed) & 3) + 1);
      while (lens.size() > 0) begin
         n = lens.pop_front();
         for (int i = 1; i <= n; i++) begin
            if (i == n) begin
               last_req = 1;
               step(2);
            end
            core_xfer_done = 1;
            step(1);
            core_xfer_done = 0;
            chk("burst_count", i, burst_count);
            chk("burst_last", i == n, burst_last);
            chk("burst_active", i < n, burst_active);
            step(1);
         end
         last_req = 0;
         step(2);
      end
      // Leaving burst mode closes an open burst
      core_xfer_done = 1;
      step(1);
      core_xfer_done = 0;
      chk("burst_active", 1, burst_active);
      host_mode = MODE_ASYNC_A;
      step(1);
      chk("burst_active", 0, burst_active);
      tally_and_finish;
   end
endmodule
